// ===== sar_digitizer_channel.sv
// one digitizer channel: track/hold command, SAR conversion, three-state output word
// assumes hold and start_n come from the control board synchronous to clock,
// and that the comparator decision is a synchronous input from the analog front end
//
// Functional notes
// - low three bits carry the range code
// - range bits driven only while enabled
// - track when hold low, capture on rise
// - start falling begins conversion clock
// - 200 kHz variants: 2.5 or 4 us
// - 100 kHz variant: about 6 us
// - completion signalled, its edge loads result
// - output register holds word, three-state
// - start loads midscale on first clock
// - result coded in offset binary
// - twelve steps, MSB toward LSB
// - comparator one means input above DAC
// - test bit one, then decide, next
// - after clock thirteen, store and signal
// - drive data only while enable active
// - one instance serves exactly one channel
// - per-clock pattern through clock thirteen
`timescale 1ns/1ps
`default_nettype none
`include "sar_digitizer_regs.svh"

module sar_digitizer_channel
    import sar_digitizer_pkg::*;
#(
    parameter variant_type VARIANT = VARIANT_SLOW_12
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic hold,
    input wire logic start_n,
    input wire logic cmp_above,
    input wire input_range_type channel_a_range_bits,
    input wire logic channel_output_enable,
    output logic track_hold_closed,
    output logic [11:0] dac_trial,
    output logic done_n,
    output logic [15:0] data_out,
    output logic [15:0] data_oe,
    output logic [2:0] range_out,
    output logic [2:0] range_oe,
    output logic [1:0] conv_state
);

    function automatic logic [`STEP_CNT_WIDTH-1:0] step_for(input variant_type v);
        unique case (v)
            VARIANT_FAST_10: step_for = `STEP_CNT_WIDTH'(`STEP_CYCLES_FAST_10);
            VARIANT_FAST_12: step_for = `STEP_CNT_WIDTH'(`STEP_CYCLES_FAST_12);
            VARIANT_SLOW_12: step_for = `STEP_CNT_WIDTH'(`STEP_CYCLES_SLOW_12);
            default: step_for = `STEP_CNT_WIDTH'(`STEP_CYCLES_SLOW_12);
        endcase
    endfunction : step_for

    // a 10-bit build keeps only the top ten decided bits
    function automatic logic [11:0] width_mask(input variant_type v);
        width_mask = (v == VARIANT_FAST_10) ? 12'hffc : 12'hfff;
    endfunction : width_mask

    conv_state_type state_q;
    conv_state_type state_d;
    logic hold_q;
    logic start_n_q;
    logic start_fall;
    logic load_mid;
    logic tick;
    logic finished;
    logic [11:0] trial;
    logic [11:0] result_q;
    logic [2:0] range_q;
    bus_word_type data_bus;
    range_bus_type range_bus;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold_q <= 1'b0;
            start_n_q <= 1'b1;
        end else begin
            hold_q <= hold;
            start_n_q <= start_n;
        end
    end

    assign start_fall = start_n_q && !start_n;
    assign load_mid = start_fall && state_q == ST_HOLD;

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_TRACK: begin
                if (hold && !hold_q) begin
                    state_d = ST_HOLD;
                end
            end
            ST_HOLD: begin
                if (load_mid) begin
                    state_d = ST_CONVERT;
                end else if (!hold) begin
                    state_d = ST_TRACK;
                end
            end
            ST_CONVERT: begin
                if (finished) begin
                    state_d = ST_DONE;
                end
            end
            ST_DONE: begin
                if (!hold) begin
                    state_d = ST_TRACK;
                end
            end
        endcase
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state_q <= ST_TRACK;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            track_hold_closed <= 1'b1;
        end else begin
            track_hold_closed <= (state_d == ST_TRACK);
        end
    end

    sar_step_timer u_timer (
        .clock(clock),
        .rstn(rstn),
        .run(state_q == ST_CONVERT),
        .step_cycles(step_for(VARIANT)),
        .tick(tick)
    );

    sar_approx_core u_core (
        .clock(clock),
        .rstn(rstn),
        .load_mid(load_mid),
        .tick(tick),
        .cmp_above(cmp_above),
        .trial(trial),
        .finished(finished)
    );

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            dac_trial <= `SAR_RESET_VALUE;
        end else begin
            dac_trial <= trial;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            done_n <= 1'b1;
        end else begin
            done_n <= !(state_d == ST_DONE);
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            result_q <= `SAR_RESET_VALUE;
            range_q <= `RANGE_RESET_VALUE;
        end else if (finished) begin
            result_q <= trial & width_mask(VARIANT);
            range_q <= channel_a_range_bits;
        end
    end

    always_comb begin
        data_bus.value = {result_q, 4'h0};
        data_bus.value[2:0] = range_q;
        data_bus.drive = {16{channel_output_enable}};
        range_bus.value = range_q;
        range_bus.drive = {3{channel_output_enable}};
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            data_out <= 16'h0000;
            data_oe <= 16'h0000;
            range_out <= 3'h0;
            range_oe <= 3'h0;
        end else begin
            data_out <= data_bus.value;
            data_oe <= data_bus.drive;
            range_out <= range_bus.value;
            range_oe <= range_bus.drive;
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            conv_state <= 2'b00;
        end else begin
            conv_state <= state_d;
        end
    end

endmodule : sar_digitizer_channel
`default_nettype wire

// ===== sar_digitizer_regs.svh
// timing counts and codes for the successive-approximation digitizer channel
// assumes a 125 MHz system clock (8 ns period)
`ifndef SAR_DIGITIZER_REGS_SVH
`define SAR_DIGITIZER_REGS_SVH

`define CLOCK_PERIOD_NS 8
// conversion times in nanoseconds, as documented per variant
`define CONV_TIME_FAST_10_NS 2500
`define CONV_TIME_FAST_12_NS 4000
`define CONV_TIME_SLOW_12_NS 6000
// thirteen conversion-clock periods fit in the conversion time (rounded down)
`define SAR_CLOCKS 13
`define STEP_CYCLES_FAST_10 ((`CONV_TIME_FAST_10_NS / `CLOCK_PERIOD_NS) / `SAR_CLOCKS)
`define STEP_CYCLES_FAST_12 ((`CONV_TIME_FAST_12_NS / `CLOCK_PERIOD_NS) / `SAR_CLOCKS)
`define STEP_CYCLES_SLOW_12 ((`CONV_TIME_SLOW_12_NS / `CLOCK_PERIOD_NS) / `SAR_CLOCKS)
`define STEP_CNT_WIDTH 6
// start-of-conversion pattern of the approximation register: the zero-volt midpoint
`define SAR_MIDSCALE 12'h800
`define SAR_RESET_VALUE 12'h000
`define RANGE_RESET_VALUE 3'h0

`endif

// ===== sar_digitizer_pkg.sv
// types shared by the digitizer channel modules
// assumes nothing beyond the header of constants
package sar_digitizer_pkg;

    typedef enum logic [2:0] {
        RANGE_8V0 = 3'b111,
        RANGE_4V0 = 3'b110,
        RANGE_2V0 = 3'b101,
        RANGE_1V0 = 3'b100,
        RANGE_0V5 = 3'b001,
        RANGE_0V25 = 3'b010,
        RANGE_0V125 = 3'b011
    } input_range_type;

    typedef enum logic [1:0] {
        VARIANT_FAST_10 = 2'b00,
        VARIANT_FAST_12 = 2'b01,
        VARIANT_SLOW_12 = 2'b10
    } variant_type;

    typedef enum logic [1:0] {
        ST_TRACK = 2'b00,
        ST_HOLD = 2'b01,
        ST_CONVERT = 2'b10,
        ST_DONE = 2'b11
    } conv_state_type;

    // a three-state bus word: value plus per-bit drive enable
    typedef struct packed {
        logic [15:0] value;
        logic [15:0] drive;
    } bus_word_type;

    typedef struct packed {
        logic [2:0] value;
        logic [2:0] drive;
    } range_bus_type;

endpackage : sar_digitizer_pkg

// ===== sar_step_timer.sv
// conversion-clock generator: a tick every step_cycles clocks while running
// assumes run is a level held for the whole conversion
`timescale 1ns/1ps
`default_nettype none
`include "sar_digitizer_regs.svh"

module sar_step_timer
    import sar_digitizer_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic run,
    input wire logic [`STEP_CNT_WIDTH-1:0] step_cycles,
    output logic tick
);

    logic [`STEP_CNT_WIDTH-1:0] count_q;

    // restarting at zero on every start keeps the first step a full period
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            count_q <= '0;
            tick <= 1'b0;
        end else if (!run) begin
            count_q <= '0;
            tick <= 1'b0;
        end else if (count_q == step_cycles - `STEP_CNT_WIDTH'(1)) begin
            count_q <= '0;
            tick <= 1'b1;
        end else begin
            count_q <= count_q + `STEP_CNT_WIDTH'(1);
            tick <= 1'b0;
        end
    end

endmodule : sar_step_timer
`default_nettype wire

// ===== sar_approx_core.sv
// twelve-bit successive-approximation register, MSB first
// assumes tick marks conversion-clock edges and cmp_above is settled at each
`timescale 1ns/1ps
`default_nettype none
`include "sar_digitizer_regs.svh"

module sar_approx_core
    import sar_digitizer_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic load_mid,
    input wire logic tick,
    input wire logic cmp_above,
    output logic [11:0] trial,
    output logic finished
);

    // one-hot pointer of the bit under test; zero once all twelve are decided
    logic [11:0] test_bit_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            trial <= `SAR_RESET_VALUE;
            test_bit_q <= '0;
            finished <= 1'b0;
        end else if (load_mid) begin
            trial <= `SAR_MIDSCALE;
            test_bit_q <= `SAR_MIDSCALE;
            finished <= 1'b0;
        end else if (tick && test_bit_q != '0) begin
            // decided bit keeps the comparator level, next lower bit goes to one
            trial <= (cmp_above ? trial : (trial & ~test_bit_q)) | (test_bit_q >> 1);
            test_bit_q <= test_bit_q >> 1;
            finished <= (test_bit_q == 12'h001);
        end else begin
            finished <= 1'b0;
        end
    end

endmodule : sar_approx_core
`default_nettype wire

// ===== front_end_model.sv
// analog front end model: track-and-hold capacitor and comparator of one channel
// assumes analog_in is a code on the same scale as the trial word
`timescale 1ns/1ps
`default_nettype none
module front_end_model (
    input wire logic clock,
    input wire logic track_hold_closed,
    input wire logic [11:0] analog_in,
    input wire logic [11:0] dac_trial,
    output logic cmp_above
);
    logic [11:0] held_q = 12'h000;
    always_ff @(posedge clock) begin
        if (track_hold_closed) begin
            held_q <= analog_in;
        end
    end
    // one when above; a tie keeps the bit so codes convert exactly
    assign cmp_above = held_q >= dac_trial;
endmodule : front_end_model
`default_nettype wire

// ===== sar_digitizer_channel_props.sv
// checker for the digitizer channel ports, bound at the foot
// assumes the bind hands over the timing variant of the instance it watches
`timescale 1ns/1ps
`default_nettype none
`include "sar_digitizer_regs.svh"
module sar_digitizer_channel_props
    import sar_digitizer_pkg::*;
#(
    parameter variant_type VARIANT = VARIANT_SLOW_12
)
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic hold,
    input wire logic start_n,
    input wire logic cmp_above,
    input wire input_range_type channel_a_range_bits,
    input wire logic channel_output_enable,
    input wire logic track_hold_closed,
    input wire logic [11:0] dac_trial,
    input wire logic done_n,
    input wire logic [15:0] data_out,
    input wire logic [15:0] data_oe,
    input wire logic [2:0] range_out,
    input wire logic [2:0] range_oe,
    input wire logic [1:0] conv_state
);
    // completion may not come later than the variant's conversion time
    localparam int CONV_MAX = (VARIANT == VARIANT_FAST_10)
        ? `CONV_TIME_FAST_10_NS / `CLOCK_PERIOD_NS
        : (VARIANT == VARIANT_FAST_12) ? `CONV_TIME_FAST_12_NS / `CLOCK_PERIOD_NS
        : `CONV_TIME_SLOW_12_NS / `CLOCK_PERIOD_NS;
    localparam int CONV_MIN = CONV_MAX * 72 / 100;
    logic [9:0] conv_cnt_q;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) conv_cnt_q <= 10'h000;
        else if (conv_state == 2'b10) conv_cnt_q <= conv_cnt_q + 10'h001;
        else conv_cnt_q <= 10'h000;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence start_seq;
        conv_state == 2'b01 && $fell(start_n);
    endsequence
    a_start_enter: assert property (start_seq |=> conv_state == 2'b10)
        else $error("conversion not entered after start");
    a_start_mid: assert property (start_seq |=> ##1 dac_trial == 12'h800)
        else $error("trial not midscale after start");
    a_conv_time: assert property ($fell(done_n) |-> conv_cnt_q >= CONV_MIN && conv_cnt_q <= CONV_MAX)
        else $error("conversion time out of range");
    a_done_state: assert property (!done_n |-> conv_state == 2'b11)
        else $error("done low outside done state");
    a_done_stands: assert property (!done_n && hold |=> !done_n)
        else $error("done released while hold high");
    a_word_stable: assert property (conv_state == 2'b11 && $past(conv_state) == 2'b11 |=> $stable(data_out))
        else $error("result changed while done");
    a_range_latched: assert property ($fell(done_n) |=> data_out[2:0] == $past(channel_a_range_bits, 2) && !data_out[3])
        else $error("range code not in low bits");
    a_data_oe_follow: assert property (data_oe == {16{$past(channel_output_enable)}})
        else $error("data enable does not follow read enable");
    a_range_oe_follow: assert property (range_oe == {3{$past(channel_output_enable)}})
        else $error("range enable does not follow read enable");
    a_track_state: assert property (track_hold_closed == (conv_state == 2'b00))
        else $error("track switch disagrees with state");
    a_start_ignored: assert property (conv_state == 2'b00 |=> conv_state != 2'b10)
        else $error("conversion started from track");
endmodule : sar_digitizer_channel_props
bind sar_digitizer_channel sar_digitizer_channel_props #(.VARIANT(VARIANT)) sar_digitizer_channel_props_inst (
    .clock(clock), .rstn(rstn), .hold(hold), .start_n(start_n), .cmp_above(cmp_above),
    .channel_a_range_bits(channel_a_range_bits), .channel_output_enable(channel_output_enable),
    .track_hold_closed(track_hold_closed), .dac_trial(dac_trial), .done_n(done_n),
    .data_out(data_out), .data_oe(data_oe), .range_out(range_out), .range_oe(range_oe),
    .conv_state(conv_state));
`default_nettype wire

// ===== test_sar_digitizer_channel.sv
// testbench for two digitizer channels, each with a front end model as far side
// assumes a slow 12-bit and a fast 10-bit channel share the board lines
`timescale 1ns/1ps
`default_nettype none
`include "sar_digitizer_regs.svh"
module test_sar_digitizer_channel
    import sar_digitizer_pkg::*;
;
    logic clock, rstn, hold, start_n, cmp_above, channel_output_enable, track_hold_closed, done_n;
    input_range_type channel_a_range_bits;
    logic [11:0] dac_trial, analog;
    logic [15:0] data_out, data_oe;
    logic [2:0] range_out, range_oe;
    logic [1:0] conv_state;
    logic fast_cmp_above, fast_track_hold_closed, fast_done_n;
    logic [11:0] fast_dac_trial;
    logic [15:0] fast_data_out, fast_data_oe;
    logic [2:0] fast_range_out, fast_range_oe;
    logic [1:0] fast_conv_state;
    int error_cnt, check_count, cycles;
    logic [11:0] vals [7] = '{12'h000, 12'hfff, 12'h800, 12'h7ff, 12'ha5c, 12'h001, 12'h5a3};
    input_range_type rg [7] = '{RANGE_8V0, RANGE_4V0, RANGE_2V0, RANGE_1V0, RANGE_0V5,
        RANGE_0V25, RANGE_0V125};
    sar_digitizer_channel sar_digitizer_channel_inst (.clock(clock), .rstn(rstn), .hold(hold),
        .start_n(start_n), .cmp_above(cmp_above), .channel_a_range_bits(channel_a_range_bits),
        .channel_output_enable(channel_output_enable), .track_hold_closed(track_hold_closed),
        .dac_trial(dac_trial), .done_n(done_n), .data_out(data_out), .data_oe(data_oe),
        .range_out(range_out), .range_oe(range_oe), .conv_state(conv_state));
    front_end_model front_end_model_inst (.clock(clock), .track_hold_closed(track_hold_closed),
        .analog_in(analog), .dac_trial(dac_trial), .cmp_above(cmp_above));
    // a 10-bit build on the same board lines converts the same samples
    sar_digitizer_channel #(.VARIANT(VARIANT_FAST_10)) sar_digitizer_channel_fast_inst (
        .clock(clock), .rstn(rstn), .hold(hold), .start_n(start_n), .cmp_above(fast_cmp_above),
        .channel_a_range_bits(channel_a_range_bits),
        .channel_output_enable(channel_output_enable),
        .track_hold_closed(fast_track_hold_closed), .dac_trial(fast_dac_trial),
        .done_n(fast_done_n), .data_out(fast_data_out), .data_oe(fast_data_oe),
        .range_out(fast_range_out), .range_oe(fast_range_oe), .conv_state(fast_conv_state));
    front_end_model front_end_model_fast_inst (.clock(clock),
        .track_hold_closed(fast_track_hold_closed), .analog_in(analog),
        .dac_trial(fast_dac_trial), .cmp_above(fast_cmp_above));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic end_sim;
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : end_sim
    task automatic test_refuse;
        @(posedge clock);
        start_n <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("idle", 16'h0004, {13'h0000, track_hold_closed, conv_state});
        @(posedge clock);
        start_n <= 1'b1;
        hold <= 1'b1;
        repeat (3) @(posedge clock);
        hold <= 1'b0;
        repeat (3) @(posedge clock);
        #1 chk("abort", 16'h0004, {13'h0000, track_hold_closed, conv_state});
    endtask : test_refuse
    task automatic test_convert(input logic [11:0] v, input input_range_type r);
        int n;
        int nf;
        @(posedge clock);
        analog <= v;
        channel_a_range_bits <= r;
        hold <= 1'b1;
        repeat (13) @(posedge clock);
        start_n <= 1'b0;
        analog <= ~v;
        n = 0;
        nf = 0;
        while (done_n !== 1'b0 && n < 1000) begin
            @(posedge clock);
            #1 n++;
            if (fast_done_n !== 1'b0) nf++;
        end
        // a run into the loop limit fails the time check
        chk("conv time", 16'h0001, {15'h0000, n <= `CONV_TIME_SLOW_12_NS / `CLOCK_PERIOD_NS});
        chk("fast time", 16'h0001, {15'h0000, nf < `CONV_TIME_FAST_10_NS / `CLOCK_PERIOD_NS});
        chk("state", 16'h0003, {14'h0000, conv_state});
        chk("fast state", 16'h0003, {14'h0000, fast_conv_state});
        // the word reaches the output flops one clock after completion
        @(posedge clock);
        #1 chk("word", {v, 1'b0, r}, data_out);
        chk("fast word", {v & 12'hffc, 1'b0, r}, fast_data_out);
        @(posedge clock);
        hold <= 1'b0;
        start_n <= 1'b1;
        channel_output_enable <= 1'b1;
        repeat (2) @(posedge clock);
        #1 chk("oe", 16'hffff, data_oe);
        chk("fast oe", 16'hffff, fast_data_oe);
        chk("range", {10'h000, 3'h7, r}, {10'h000, range_oe, range_out});
        chk("held", {v, 1'b0, r}, data_out);
        chk("track", 16'h0004, {13'h0000, track_hold_closed, conv_state});
        @(posedge clock);
        channel_output_enable <= 1'b0;
        repeat (2) @(posedge clock);
        #1 chk("off", 16'h0000, data_oe | fast_data_oe | {13'h0000, range_oe});
    endtask : test_convert
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            error_cnt++;
            end_sim();
        end
    end
    initial begin
        rstn = 1'b0;
        hold = 1'b0;
        start_n = 1'b1;
        channel_output_enable = 1'b0;
        analog = 12'h000;
        channel_a_range_bits = RANGE_8V0;
        repeat (4) @(posedge clock);
        rstn <= 1'b1;
        test_refuse();
        for (int i = 0; i < 7; i++) begin
            test_convert(vals[i], rg[i]);
        end
        end_sim();
    end
endmodule : test_sar_digitizer_channel
`default_nettype wire
